/* bench/mcr_host_model.sv */
// Host model: drives the serial pins, MSB first, sclk idle high.
// Assumes mclk from the bench; pins change at its falling edge.
`timescale 1ns/1ps
module mcr_host_model (
    // Clock
    input  wire mclk,
    // Serial pins
    output reg  sclk,
    output reg  din,
    output reg  cs_n,
    input  wire dout
);
    initial begin
        sclk = 1'b1;
        din  = 1'b1;
        cs_n = 1'b1;
    end
    // Command byte goes first, reserved bits forced low
    task automatic xfer(input logic [7:0] cmd, input logic [39:0] data, input int nb,
                        output logic [39:0] rd);
        logic       b;
        logic [7:0] c;
        rd   = 40'h0;
        c    = cmd & 8'h9f;
        cs_n = 1'b0;
        for (int i = 0; i < 8 + nb; i++) begin
            if (i >= 8)
                rd = {rd[38:0], dout};
            b = (i < 8) ? c[7 - i] : data[nb + 7 - i];
            din = b;
            // Data settles well before the fall; pins pass a synchroniser
            repeat (3) @(negedge mclk);
            sclk = 1'b0;
            repeat (6) @(negedge mclk);
            sclk = 1'b1;
            repeat (6) @(negedge mclk);
        end
        cs_n = 1'b1;
        din  = ~din;
    endtask
endmodule

/* bench/mcr_top_chk.sv */
// Checker for the command decoder and configuration register ports.
// Assumes binding onto mcr_top; sees only its ports, one clock domain.
`timescale 1ns/1ps
module mcr_top_chk #(
    parameter DATA_W = 40
) (
    // Clock and reset
    input wire              mclk,
    input wire              rst_n,
    // Watched ports
    input wire              cs_n,
    input wire [4:0]        ext_addr,
    input wire              ext_wr,
    input wire [DATA_W-1:0] ext_wr_data,
    input wire              thermal_done,
    input wire              thermal_conv_start,
    input wire              soft_chip_reset,
    input wire              dip_detect_off,
    input wire              pulse_out_off,
    input wire              hipass_bypass,
    input wire              calibration_select,
    input wire [1:0]        wave_rate_sel,
    input wire [1:0]        wave_source_sel,
    input wire              wave_sample_en
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic [9:0]  hold_cnt;
    logic [10:0] gap;
    logic [1:0]  rate_prev;
    logic        seen;
    logic        rchg;
    ////////////////////////////////////////////////////////////////////////////////
    // Helper counters; a rate change spoils one interval, a soft reset every interval it overlaps
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hold_cnt  <= 10'h000;
            gap       <= 11'h000;
            rate_prev <= 2'h0;
            seen      <= 1'b0;
            rchg      <= 1'b0;
        end else begin
            hold_cnt  <= soft_chip_reset ? hold_cnt + 10'h001 : 10'h000;
            rate_prev <= wave_rate_sel;
            if (wave_sample_en) begin
                gap  <= 11'h000;
                seen <= 1'b1;
                rchg <= 1'b0;
            end else begin
                gap  <= gap + 11'h001;
                rchg <= rchg | (wave_rate_sel != rate_prev) | soft_chip_reset;
            end
        end
    end
    sequence s_soft_chip_reset_end;
        $fell(soft_chip_reset);
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    AST_EXT_WR_ADDR: assert property (ext_wr |-> !(ext_addr inside {[5'h01:5'h06], 5'h12}))
        else $error("write strobe to a read-only or config address");
    AST_EXT_WR_PULSE: assert property (ext_wr |=> !ext_wr)
        else $error("write strobe longer than one cycle");
    AST_WR_DATA_HOLD: assert property (!ext_wr |-> $stable(ext_wr_data))
        else $error("write data moved without a write");
    AST_THERM_CLR: assert property (thermal_done |=> !thermal_conv_start)
        else $error("thermal start bit not cleared");
    AST_SOFT_CHIP_RESET_MAX: assert property (hold_cnt <= 10'd450)
        else $error("soft reset held too long");
    AST_SOFT_CHIP_RESET_LEN: assert property (s_soft_chip_reset_end |-> hold_cnt >= 10'd449)
        else $error("soft reset hold too short");
    AST_SOFT_CHIP_RESET_CFG: assert property (s_soft_chip_reset_end |-> ##[0:2] (dip_detect_off && pulse_out_off
        && !hipass_bypass && !calibration_select && wave_rate_sel == 2'b00))
        else $error("config not back to reset value after soft reset");
    AST_RATE_GAP: assert property (wave_sample_en && seen && !rchg && wave_rate_sel == rate_prev
        |-> gap == (11'd128 << wave_rate_sel) - 11'd1)
        else $error("sample enable period wrong");
    AST_CFG_QUIET: assert property (cs_n && $past(cs_n, 4) && !soft_chip_reset
        && !$past(soft_chip_reset, 2) |-> $stable({wave_source_sel, wave_rate_sel}))
        else $error("config changed with no transfer");
endmodule

/* bench/test_mcr_top.sv */
// Bench for the command decoder and configuration register.
// Assumes the host model on the serial pins and a stub for other registers.
`timescale 1ns/1ps
module test_mcr_top;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        thermal_done = 1'b0;
    logic [39:0] ext_rd_data = 40'h00000000a5;
    wire         sclk, din, cs_n, dout, ext_wr, soft_chip_reset, wave_sample_en;
    wire  [4:0]  ext_addr;
    wire  [39:0] ext_wr_data;
    wire  [1:0]  wave_rate_sel, wave_source_sel;
    wire         hpb, lpb, pof, ddo, cpd, tcs, cal, sf1, sf2, swp;
    wire  [14:0] cfg = {wave_source_sel, wave_rate_sel, swp, sf2, sf1, cal, 1'b0, tcs, cpd, ddo,
                        pof, lpb, hpb};
    int          error_cnt = 0;
    int          compares = 0;
    int          wr_cnt = 0;
    always #20 mclk = ~mclk;
    always @(negedge mclk) if (ext_wr === 1'b1) wr_cnt++;
    mcr_host_model i_host (.mclk(mclk), .sclk(sclk), .din(din), .cs_n(cs_n), .dout(dout));
    mcr_top #(.DATA_W(40)) i_dut (.mclk(mclk), .rst_n(rst_n), .sclk(sclk), .din(din),
        .cs_n(cs_n), .dout(dout), .ext_addr(ext_addr), .ext_wr(ext_wr),
        .ext_wr_data(ext_wr_data), .ext_rd_data(ext_rd_data), .thermal_done(thermal_done),
        .hipass_bypass(hpb), .post_mult_lowpass_bypass(lpb), .pulse_out_off(pof),
        .dip_detect_off(ddo), .converters_powerdown(cpd), .thermal_conv_start(tcs),
        .calibration_select(cal), .short_first_inputs(sf1), .short_second_inputs(sf2),
        .swap_inputs(swp), .wave_rate_sel(wave_rate_sel), .wave_source_sel(wave_source_sel),
        .soft_chip_reset(soft_chip_reset), .wave_sample_en(wave_sample_en));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        if (error_cnt == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [39:0] exp, input logic [39:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask
    task automatic acc(input logic [7:0] cmd, input logic [39:0] d, input int nb,
                       output logic [39:0] rd);
        i_host.xfer(cmd, d, nb, rd);
        repeat (8) @(negedge mclk);
    endtask
    task automatic cfg_rw(input logic [15:0] v);
        logic [39:0] r;
        acc(8'h86, {24'h0, v}, 16, r);
        chk("config outputs", {24'h0, v & 16'h7fbf}, {25'h0, cfg});
        acc(8'h06, 40'h0, 16, r);
        chk("config readback", {24'h0, v}, r);
    endtask
    task automatic wait_pulse(output int n);
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (wave_sample_en !== 1'b1 && n < 2100);
        if (n >= 2100) begin
            error_cnt++;
            report_and_stop;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        logic [39:0] r;
        chk("config outputs", 40'h000c, {25'h0, cfg});
        acc(8'h06, 40'h0, 16, r);
        chk("config readback", 40'h000c, r);
    endtask
    task automatic t_cfg;
        cfg_rw(16'h5f9f);
        cfg_rw(16'h2700);
        cfg_rw(16'h2420);
        thermal_done = 1'b1;
        @(negedge mclk);
        thermal_done = 1'b0;
        @(negedge mclk);
        chk("thermal start", 40'h0, {39'h0, tcs});
    endtask
    task automatic t_ext;
        int          c;
        logic [39:0] r;
        c = wr_cnt;
        acc(8'h87, 40'h0abc, 16, r);
        chk("ext_wr count", 40'(c + 1), 40'(wr_cnt));
        chk("ext_addr", 40'h07, {35'h0, ext_addr});
        chk("ext_wr_data", 40'h0abc, ext_wr_data);
        acc(8'h88, 40'h3c, 8, r);
        chk("ext_wr_data", 40'h3c, ext_wr_data);
        acc(8'h84, 40'h5a, 8, r);
        chk("ext_wr count", 40'(c + 2), 40'(wr_cnt));
        acc(8'h0f, 40'h0, 8, r);
        chk("read data", 40'ha5, r);
        chk("ext_addr", 40'h0f, {35'h0, ext_addr});
    endtask
    task automatic t_rate(input logic [1:0] code, input int per);
        int n;
        logic [39:0] r;
        acc(8'h86, 40'h000c | (40'(code) << 11), 16, r);
        wait_pulse(n);
        wait_pulse(n);
        wait_pulse(n);
        chk("sample period", 40'(per), 40'(n));
    endtask
    task automatic t_soft_chip_reset;
        logic [39:0] r;
        acc(8'h86, 40'h0040, 16, r);
        chk("soft reset", 40'h1, {39'h0, soft_chip_reset});
        repeat (480) @(negedge mclk);
        chk("soft reset", 40'h0, {39'h0, soft_chip_reset});
        acc(8'h06, 40'h0, 16, r);
        chk("config readback", 40'h000c, r);
    endtask
    initial begin
        repeat (20) @(negedge mclk);
        rst_n = 1'b1;
        repeat (4) @(negedge mclk);
        t_reset;
        t_cfg;
        t_ext;
        t_rate(2'b00, 128);
        t_rate(2'b01, 256);
        t_rate(2'b10, 512);
        t_rate(2'b11, 1024);
        t_soft_chip_reset;
        report_and_stop;
    end
endmodule
bind mcr_top mcr_top_chk #(.DATA_W(DATA_W)) i_chk (.mclk(mclk), .rst_n(rst_n), .cs_n(cs_n),
    .ext_addr(ext_addr), .ext_wr(ext_wr), .ext_wr_data(ext_wr_data),
    .thermal_done(thermal_done), .thermal_conv_start(thermal_conv_start),
    .soft_chip_reset(soft_chip_reset), .dip_detect_off(dip_detect_off),
    .pulse_out_off(pulse_out_off), .hipass_bypass(hipass_bypass),
    .calibration_select(calibration_select), .wave_rate_sel(wave_rate_sel),
    .wave_source_sel(wave_source_sel), .wave_sample_en(wave_sample_en));

/* rtl/mcr_defines.vh */
// Constants for the command decoder and operating configuration register.
// Assumes a single 25 MHz master clock and the serial pins of the device.
//
// What this block does
// - An 8-bit write-only command byte opens every serial transfer.
// - Command bits four to zero address the register of the next transfer.
// - Command bit seven one means write, zero means read.
// - Configuration bit zero bypasses the first channel high-pass filter.
// - Configuration bit one bypasses the post-multiplier low-pass filter.
// - Bit two stops the energy pulse output; bit three stops dip detection.
// - Bit four powers down both converters; keep it zero normally.
// - Bit five starts a thermal conversion and self-clears when it finishes.
// - Bit six resets the chip; host waits 18 us before the next transfer.
// - Bit seven selects calibration mode instead of normal metering.
// - Bit eight shorts first converter inputs; bit nine shorts the second's.
// - Bit ten swaps the two input pairs between the converters.
// - Bits twelve, eleven set waveform rate: clock over 128, 256, 512, 1024.
// - Configuration register is 16 bits, read/write anytime, resets to 000c.
// - Bits fourteen, thirteen select waveform source; code 01 is reserved.
`ifndef MCR_DEFINES_VH
`define MCR_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// Command byte fields
`define MCR_CMD_DIR_BIT    7
`define MCR_CMD_ADDR_HI    4

////////////////////////////////////////////////////////////////////////////////
// Register addresses
`define MCR_ADDR_WAVE      5'h01
`define MCR_ADDR_ENERGY    5'h02
`define MCR_ADDR_RSTENERGY 5'h03
`define MCR_ADDR_STATUS    5'h04
`define MCR_ADDR_RSTSTATUS 5'h05
`define MCR_ADDR_OPCFG     5'h06
`define MCR_ADDR_TEMP      5'h12

////////////////////////////////////////////////////////////////////////////////
// Operating configuration fields and reset value
`define MCR_OPCFG_RESET    16'h000c
`define MCR_B_HPF          0
`define MCR_B_LPF          1
`define MCR_B_PULSE        2
`define MCR_B_DIP          3
`define MCR_B_PDN          4
`define MCR_B_THERM        5
`define MCR_B_SOFT_CHIP_RESET        6
`define MCR_B_CAL          7
`define MCR_B_SHORT1       8
`define MCR_B_SHORT2       9
`define MCR_B_SWAP         10
`define MCR_B_RATE_LO      11
`define MCR_B_RATE_HI      12
`define MCR_B_SRC_LO       13
`define MCR_B_SRC_HI       14

////////////////////////////////////////////////////////////////////////////////
// Timing
`define MCR_CLK_NS         40
`define MCR_SOFT_CHIP_RESET_HOLD_NS  18000
`define MCR_RATE_DIV_BASE  128

`endif

/* rtl/mcr_rate_div.v */
// Waveform sample rate divider: one-cycle enable pulse per update period.
// Assumes the master clock and a rate code from the configuration register.
`timescale 1ns/1ps
`include "mcr_defines.vh"

module mcr_rate_div (
    // Clock and reset
    input  wire       mclk,
    input  wire       rst_n,
    // Control
    input  wire [1:0] rate_sel,
    // Enable out
    output reg        sample_en
);

    reg  [9:0] cnt;
    wire [9:0] last;

    // Code 11 gives clock over 1024; base period doubles per code step
    assign last = (10'h080 << rate_sel) - 10'h001;

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt       <= 10'h000;
            sample_en <= 1'b0;
        end else begin
            // A rate change mid-period takes effect at once; a count already past the new end wraps next cycle
            if (cnt >= last) begin
                cnt       <= 10'h000;
                sample_en <= 1'b1;
            end else begin
                cnt       <= cnt + 10'h001;
                sample_en <= 1'b0;
            end
        end
    end

endmodule

/* rtl/mcr_top.v */
// Command byte decoder, serial register access and operating configuration.
// Assumes host-driven serial pins; other registers live outside on ext_* ports.
`timescale 1ns/1ps
`include "mcr_defines.vh"

module mcr_top #(
    parameter DATA_W = 40
) (
    // Clock and reset
    input  wire              mclk,
    input  wire              rst_n,
    // Serial pins from the host
    input  wire              sclk,
    input  wire              din,
    input  wire              cs_n,
    output reg               dout,
    // Access to the remaining registers
    output reg  [4:0]        ext_addr,
    output reg               ext_wr,
    output reg  [DATA_W-1:0] ext_wr_data,
    input  wire [DATA_W-1:0] ext_rd_data,
    // Thermal conversion handshake
    input  wire              thermal_done,
    // Configuration controls
    output wire              hipass_bypass,
    output wire              post_mult_lowpass_bypass,
    output wire              pulse_out_off,
    output wire              dip_detect_off,
    output wire              converters_powerdown,
    output wire              thermal_conv_start,
    output wire              calibration_select,
    output wire              short_first_inputs,
    output wire              short_second_inputs,
    output wire              swap_inputs,
    output wire [1:0]        wave_rate_sel,
    output wire [1:0]        wave_source_sel,
    output reg               soft_chip_reset,
    output wire              wave_sample_en
);

    ////////////////////////////////////////////////////////////////////////////
    // Constants
    localparam integer HOLD_CYC_I = (`MCR_SOFT_CHIP_RESET_HOLD_NS + `MCR_CLK_NS - 1) / `MCR_CLK_NS;
    localparam [8:0]   HOLD_CYC   = HOLD_CYC_I[8:0];
    localparam [1:0] ST_CMD  = 2'd0;
    localparam [1:0] ST_LOAD = 2'd1;
    localparam [1:0] ST_WR   = 2'd2;
    localparam [1:0] ST_RD   = 2'd3;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers, three stages each
    reg  [2:0] sclk_s;
    reg  [2:0] din_s;
    reg  [2:0] cs_s;
    reg        sclk_q;
    reg        cs_q;

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_s <= 3'h7;
            din_s  <= 3'h0;
            cs_s   <= 3'h7;
            sclk_q <= 1'b1;
            cs_q   <= 1'b1;
        end else begin
            sclk_s <= {sclk_s[1:0], sclk};
            din_s  <= {din_s[1:0], din};
            cs_s   <= {cs_s[1:0], cs_n};
            // A level counts only once stages two and three agree
            if (sclk_s[1] == sclk_s[2])
                sclk_q <= sclk_s[2];
            if (cs_s[1] == cs_s[2])
                cs_q <= cs_s[2];
        end
    end

    wire sclk_fall = (sclk_s[1] == sclk_s[2]) && !sclk_s[2] && sclk_q;
    wire sclk_rise = (sclk_s[1] == sclk_s[2]) && sclk_s[2] && !sclk_q;
    wire selected  = !cs_q;

    ////////////////////////////////////////////////////////////////////////////
    // Transfer length in bytes for each address
    function [2:0] xfer_bytes;
        input [4:0] a;
        begin
            case (a)
                5'h01:                         xfer_bytes = 3'd3;
                5'h02, 5'h03:                  xfer_bytes = 3'd5;
                5'h06, 5'h07, 5'h0b, 5'h0d,
                5'h0e:                         xfer_bytes = 3'd2;
                default:                       xfer_bytes = 3'd1;
            endcase
        end
    endfunction

    function read_only;
        input [4:0] a;
        begin
            read_only = (a >= `MCR_ADDR_WAVE && a <= `MCR_ADDR_RSTSTATUS) ||
                        (a == `MCR_ADDR_TEMP);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Serial engine and configuration register
    reg [15:0]       opcfg;
    reg [1:0]        state;
    reg [5:0]        bit_cnt;
    reg [5:0]        bit_total;
    reg [7:0]        cmd_sh;
    reg [DATA_W-1:0] data_sh;
    reg [8:0]        hold_cnt;

    wire [7:0]  cmd_next = {cmd_sh[6:0], din_s[2]};
    wire [DATA_W-1:0] data_next = {data_sh[DATA_W-2:0], din_s[2]};
    wire [DATA_W-1:0] rd_val = (ext_addr == `MCR_ADDR_OPCFG) ?
                               {{(DATA_W-16){1'b0}}, opcfg} : ext_rd_data;
    wire [5:0]  rd_shift = 6'd40 - bit_total;
    wire        holding  = (hold_cnt != 9'h000);

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            opcfg           <= `MCR_OPCFG_RESET;
            state           <= ST_CMD;
            bit_cnt         <= 6'h00;
            bit_total       <= 6'h08;
            cmd_sh          <= 8'h00;
            data_sh         <= {DATA_W{1'b0}};
            ext_addr        <= 5'h00;
            ext_wr          <= 1'b0;
            ext_wr_data     <= {DATA_W{1'b0}};
            dout            <= 1'b0;
            hold_cnt        <= 9'h000;
            soft_chip_reset <= 1'b0;
        end else if (holding) begin
            // Engine state and opcfg rest in reset for the hold time; serial input ignored
            hold_cnt        <= hold_cnt - 9'h001;
            soft_chip_reset <= (hold_cnt != 9'h001);
            opcfg           <= `MCR_OPCFG_RESET;
            state           <= ST_CMD;
            bit_cnt         <= 6'h00;
            ext_wr          <= 1'b0;
            dout            <= 1'b0;
        end else begin
            ext_wr <= 1'b0;
            // Conversion done clears the start bit unless a write sets it now
            if (thermal_done)
                opcfg[`MCR_B_THERM] <= 1'b0;
            if (!selected) begin
                state   <= ST_CMD;
                bit_cnt <= 6'h00;
            end else begin
                case (state)
                    ST_CMD: begin
                        if (sclk_fall) begin
                            cmd_sh  <= cmd_next;
                            bit_cnt <= bit_cnt + 6'h01;
                            if (bit_cnt == 6'd7) begin
                                // Bits five and six are don't-care here
                                ext_addr  <= cmd_next[`MCR_CMD_ADDR_HI:0];
                                bit_total <= {xfer_bytes(cmd_next[4:0]), 3'b000};
                                // Stale bits must not leak above a short write
                                data_sh   <= {DATA_W{1'b0}};
                                bit_cnt   <= 6'h00;
                                state     <= cmd_next[`MCR_CMD_DIR_BIT] ?
                                             ST_WR : ST_LOAD;
                            end
                        end
                    end
                    ST_LOAD: begin
                        // Read value taken one cycle after ext_addr settles
                        data_sh <= rd_val << rd_shift;
                        state   <= ST_RD;
                    end
                    ST_WR: begin
                        if (sclk_fall) begin
                            data_sh <= data_next;
                            bit_cnt <= bit_cnt + 6'h01;
                            if (bit_cnt == bit_total - 6'h01) begin
                                bit_cnt <= 6'h00;
                                state   <= ST_CMD;
                                if (ext_addr == `MCR_ADDR_OPCFG) begin
                                    opcfg <= data_next[15:0];
                                    if (data_next[`MCR_B_SOFT_CHIP_RESET]) begin
                                        hold_cnt        <= HOLD_CYC;
                                        soft_chip_reset <= 1'b1;
                                    end
                                end else if (!read_only(ext_addr)) begin
                                    ext_wr      <= 1'b1;
                                    ext_wr_data <= data_next;
                                end
                            end
                        end
                    end
                    ST_RD: begin
                        if (sclk_rise) begin
                            dout    <= data_sh[DATA_W-1];
                            data_sh <= {data_sh[DATA_W-2:0], 1'b0};
                        end
                        if (sclk_fall) begin
                            bit_cnt <= bit_cnt + 6'h01;
                            if (bit_cnt == bit_total - 6'h01) begin
                                bit_cnt <= 6'h00;
                                state   <= ST_CMD;
                            end
                        end
                    end
                    default: state <= ST_CMD;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration fields straight from the register
    assign hipass_bypass            = opcfg[`MCR_B_HPF];
    assign post_mult_lowpass_bypass = opcfg[`MCR_B_LPF];
    assign pulse_out_off            = opcfg[`MCR_B_PULSE];
    assign dip_detect_off           = opcfg[`MCR_B_DIP];
    assign converters_powerdown     = opcfg[`MCR_B_PDN];
    assign thermal_conv_start       = opcfg[`MCR_B_THERM];
    assign calibration_select       = opcfg[`MCR_B_CAL];
    assign short_first_inputs       = opcfg[`MCR_B_SHORT1];
    assign short_second_inputs      = opcfg[`MCR_B_SHORT2];
    assign swap_inputs              = opcfg[`MCR_B_SWAP];
    assign wave_rate_sel            = opcfg[`MCR_B_RATE_HI:`MCR_B_RATE_LO];
    // Reserved code 01 is passed through; the sampler treats it as undefined
    assign wave_source_sel          = opcfg[`MCR_B_SRC_HI:`MCR_B_SRC_LO];

    ////////////////////////////////////////////////////////////////////////////
    // Waveform update rate
    mcr_rate_div u_rate (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .rate_sel  (wave_rate_sel),
        .sample_en (wave_sample_en)
    );

endmodule
